// ===== design/umer_park_q.sv
// Queue of parked report block addresses handed in by the host.
// Assumes push is never asserted while full and pop never while empty.
`timescale 1ns/1ps
module umer_park_q #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       push,
  input  wire logic [WIDTH-1:0]           push_data,
  input  wire logic                       pop,
  output logic      [WIDTH-1:0]           head,
  output logic                            empty,
  output logic                            full,
  output logic      [$clog2(DEPTH):0]     count
);
  localparam int AW = $clog2(DEPTH);

  // Pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_param_chk
    $error("umer_park_q: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;

  always_ff @(posedge pclk) begin
    if (push) begin
      mem_r[wr_ptr_r[AW-1:0]] <= push_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

  assign head  = mem_r[rd_ptr_r[AW-1:0]];
  assign count = wr_ptr_r - rd_ptr_r;
  assign empty = (wr_ptr_r == rd_ptr_r);
  assign full  = (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]) && (wr_ptr_r[AW] != rd_ptr_r[AW]);

endmodule : umer_park_q

// ===== design/umer_reporter.sv
// Unsolicited modem event reporter for one channel, with APB registers.
// Assumes modem lines and cable code are synchronous to pclk and that the
// response list accepts a finished block through resp_valid / resp_ready.
// What this block does
// - Mask byte counts only while the mask enable bit is set.
// - Mask enable clear means no modem line change ever reports.
// - Mask bits 17 to 23 qualify status bits 9 to 15.
// - Parked report blocks stay parked until an unsolicited event occurs.
// - Write the first parameter longword, then queue the block.
// - Reason byte: 01 modem status change, 02 cable code change.
// - Modem report carries current modem status in bits 15 to 9, with bit 8 set.
// - Cable report carries the new cable code in bits 15 to 8.
// - Status bits 9 to 15 in the documented line order.
// - Each queued block sets response-available flag bit 14, may interrupt.
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module umer_reporter #(
  parameter int PARK_DEPTH = 4
) (
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [7:0]                       paddr,
  input  wire logic [31:0]                      pwdata,
  output logic      [31:0]                      prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  input  wire logic [umer_pkg::NUM_LINES-1:0]   modem_lines,
  input  wire logic [7:0]                       cable_code,
  output logic                                  resp_valid,
  input  wire logic                             resp_ready,
  output logic      [31:0]                      resp_addr,
  output logic      [31:0]                      resp_param,
  output logic                                  irq
);

  if (PARK_DEPTH < 2 || PARK_DEPTH > 64) begin : g_depth_chk
    $error("umer_reporter: PARK_DEPTH out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  localparam int CW = $clog2(PARK_DEPTH) + 1;

  umer_pkg::umer_state_t               state_r;
  logic [31:0]                         mctl_r;
  logic [31:0]                         imask_r;
  logic [31:0]                         flag_r;
  logic [31:0]                         flag_nxt;
  logic [31:0]                         rd_cap_r;
  logic [31:0]                         prdata_r;
  logic                                primed_r;
  logic [umer_pkg::NUM_LINES-1:0]      lines_prev_r;
  logic [7:0]                          cable_prev_r;
  logic                                modem_pend_r;
  logic                                cable_pend_r;
  logic                                rsn_modem_r;
  logic [31:0]                         resp_addr_r;
  logic [31:0]                         resp_param_r;
  logic [umer_pkg::NUM_LINES-1:0]      sig_lines;
  logic                                modem_evt;
  logic                                cable_evt;
  logic                                wr_acc;
  logic                                rd_setup;
  logic                                rd_acc_flag;
  logic                                park_push;
  logic                                park_pop;
  logic                                park_empty;
  logic                                park_full;
  logic [31:0]                         park_head;
  logic [CW-1:0]                       park_count;
  logic                                queued;
  logic                                mapped;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode: zero wait states, read data captured in the setup cycle
  assign pready   = 1'b1;
  assign wr_acc   = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign rd_acc_flag = psel && penable && !pwrite && (paddr == umer_pkg::ADDR_FLAG);
  assign mapped   = (paddr == umer_pkg::ADDR_MCTL)  || (paddr == umer_pkg::ADDR_PARK)  ||
                    (paddr == umer_pkg::ADDR_FLAG)  || (paddr == umer_pkg::ADDR_IMASK) ||
                    (paddr == umer_pkg::ADDR_LASTP) || (paddr == umer_pkg::ADDR_LASTA) ||
                    (paddr == umer_pkg::ADDR_LINES);
  assign pslverr  = psel && penable && !mapped;
  assign prdata   = prdata_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      rd_cap_r <= 32'h0000_0000;
    end else if (rd_setup) begin
      rd_cap_r <= (paddr == umer_pkg::ADDR_FLAG) ? flag_r : 32'h0000_0000;
      case (paddr)
        umer_pkg::ADDR_MCTL:  prdata_r <= mctl_r;
        umer_pkg::ADDR_PARK:  prdata_r <= 32'(park_count);
        umer_pkg::ADDR_FLAG:  prdata_r <= flag_r;
        umer_pkg::ADDR_IMASK: prdata_r <= imask_r;
        umer_pkg::ADDR_LASTP: prdata_r <= resp_param_r;
        umer_pkg::ADDR_LASTA: prdata_r <= resp_addr_r;
        umer_pkg::ADDR_LINES: prdata_r <= {22'h00_0000, cable_pend_r, modem_pend_r, modem_lines, 1'b0};
        default:              prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // Only the mask byte and the interrupt mask are writable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mctl_r  <= umer_pkg::MCTL_RST;
      imask_r <= umer_pkg::IMASK_RST;
    end else if (wr_acc) begin
      if (paddr == umer_pkg::ADDR_MCTL) begin
        mctl_r <= pwdata & 32'h00ff_0000;
      end
      if (paddr == umer_pkg::ADDR_IMASK) begin
        imask_r <= pwdata & umer_pkg::FLAG_USED;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parked report blocks
  assign park_push = wr_acc && (paddr == umer_pkg::ADDR_PARK) && !park_full;

  umer_park_q #(
    .WIDTH (32),
    .DEPTH (PARK_DEPTH)
  ) u_park_q (
    .pclk      (pclk),
    .presetn   (presetn),
    .push      (park_push),
    .push_data (pwdata),
    .pop       (park_pop),
    .head      (park_head),
    .empty     (park_empty),
    .full      (park_full),
    .count     (park_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Event detection
  // Mask gated by enable
  assign sig_lines = mctl_r[umer_pkg::MASK_EN_BIT] ?
                     mctl_r[umer_pkg::MASK_LSB +: umer_pkg::NUM_LINES] : '0;
  assign modem_evt = primed_r && |((modem_lines ^ lines_prev_r) & sig_lines);
  assign cable_evt = primed_r && (cable_code != cable_prev_r);

  // First cycle after reset only learns the line levels, so no false change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primed_r     <= 1'b0;
      lines_prev_r <= '0;
      cable_prev_r <= 8'h00;
    end else begin
      primed_r     <= 1'b1;
      lines_prev_r <= modem_lines;
      cable_prev_r <= cable_code;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modem_pend_r <= 1'b0;
      cable_pend_r <= 1'b0;
    end else begin
      if (modem_evt) begin
        modem_pend_r <= 1'b1;
      end else if (state_r == umer_pkg::ST_FILL && rsn_modem_r) begin
        modem_pend_r <= 1'b0;
      end
      if (cable_evt) begin
        cable_pend_r <= 1'b1;
      end else if (state_r == umer_pkg::ST_FILL && !rsn_modem_r) begin
        cable_pend_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Report sequencer: take a block, write its first longword, queue it
  // Wait for event with block
  assign park_pop = (state_r == umer_pkg::ST_IDLE) && !park_empty && (modem_pend_r || cable_pend_r);
  assign queued   = (state_r == umer_pkg::ST_QUEUE) && resp_ready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= umer_pkg::ST_IDLE;
    end else begin
      case (state_r)
        umer_pkg::ST_IDLE:  state_r <= park_pop ? umer_pkg::ST_FILL : umer_pkg::ST_IDLE;
        umer_pkg::ST_FILL:  state_r <= umer_pkg::ST_QUEUE;
        umer_pkg::ST_QUEUE: state_r <= resp_ready ? umer_pkg::ST_IDLE : umer_pkg::ST_QUEUE;
        default:            state_r <= umer_pkg::ST_IDLE;
      endcase
    end
  end

  // Modem changes take priority; a cable change waits for the next block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsn_modem_r <= 1'b0;
      resp_addr_r <= 32'h0000_0000;
    end else if (park_pop) begin
      rsn_modem_r <= modem_pend_r;
      resp_addr_r <= park_head;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_param_r <= 32'h0000_0000;
    end else if (state_r == umer_pkg::ST_FILL) begin
      resp_param_r <= 32'h0000_0000;
      if (rsn_modem_r) begin
        resp_param_r[umer_pkg::PARAM_REASON_LSB +: 8]                   <= umer_pkg::REASON_MODEM;
        resp_param_r[umer_pkg::PARAM_PRESENT_BIT]                       <= 1'b1;
        resp_param_r[umer_pkg::PARAM_STATUS_LSB +: umer_pkg::NUM_LINES] <= modem_lines;
      end else begin
        resp_param_r[umer_pkg::PARAM_REASON_LSB +: 8] <= umer_pkg::REASON_CABLE;
        resp_param_r[umer_pkg::PARAM_DETAIL_LSB +: 8] <= cable_code;
      end
    end
  end

  assign resp_valid = (state_r == umer_pkg::ST_QUEUE);
  assign resp_addr  = resp_addr_r;
  assign resp_param = resp_param_r;

  ////////////////////////////////////////////////////////////////////////////
  // Flags and interrupt: read clears only bits the read returned, set wins
  // Response-available and parked-queue overflow flags
  always_comb begin
    flag_nxt = flag_r;
    if (rd_acc_flag) begin
      flag_nxt = flag_r & ~rd_cap_r;
    end
    if (queued) begin
      flag_nxt[umer_pkg::FLAG_RESPONSE_AVAILABLE_BIT] = 1'b1;
    end
    if (wr_acc && (paddr == umer_pkg::ADDR_PARK) && park_full) begin
      flag_nxt[umer_pkg::FLAG_PARK_OVF_BIT] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= umer_pkg::FLAG_RST;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign irq = |(flag_r & imask_r);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_mask_off_quiet: assert property ($rose(modem_pend_r) |-> $past(mctl_r[umer_pkg::MASK_EN_BIT]))
    else $error("modem event raised with mask disabled");
  a_masked_change: assert property (
    (primed_r && mctl_r[16] && |((modem_lines ^ lines_prev_r) & mctl_r[23:17])) |=> modem_pend_r)
    else $error("qualified line change not held pending");
  a_unmasked_ignored: assert property ((!modem_pend_r && !(|((modem_lines ^ lines_prev_r) & sig_lines)))
    |=> !modem_pend_r)
    else $error("pending set without a qualified change");
  a_no_block_wait: assert property ((state_r == umer_pkg::ST_IDLE && park_empty) |=> state_r == umer_pkg::ST_IDLE)
    else $error("report started with no parked block");
  a_fill_then_queue: assert property ((state_r == umer_pkg::ST_FILL) |=> resp_valid)
    else $error("fill not followed by queueing");
  a_resp_hold: assert property (
    (resp_valid && !resp_ready) |=> (resp_valid && $stable(resp_param) && $stable(resp_addr)))
    else $error("queued block changed before acceptance");
  a_reason_code: assert property (resp_valid |-> (resp_param[7:0] == 8'h01 || resp_param[7:0] == 8'h02))
    else $error("reserved reason code returned");
  a_modem_detail: assert property (
    (state_r == umer_pkg::ST_FILL && rsn_modem_r)
    |=> (resp_param[15:9] == $past(modem_lines) && resp_param[8] && resp_param[7:0] == 8'h01))
    else $error("modem status misplaced in report");
  a_cable_detail: assert property (
    (state_r == umer_pkg::ST_FILL && !rsn_modem_r)
    |=> (resp_param[15:8] == $past(cable_code) && resp_param[7:0] == 8'h02))
    else $error("cable code misplaced in report");
  a_resp_flag: assert property (
    (resp_valid && resp_ready) |=> (flag_r[14] ##1 (flag_r[14] || rd_acc_flag || $past(rd_acc_flag))))
    else $error("response flag not set after queueing");
  a_irq_follows: assert property ((flag_r[14] && imask_r[14]) |-> irq)
    else $error("interrupt missing for enabled flag");

  c_modem_report: cover property (resp_valid && resp_ready && resp_param[7:0] == 8'h01);
  c_cable_report: cover property (resp_valid && resp_ready && resp_param[7:0] == 8'h02);
  c_held_event:   cover property (modem_pend_r && park_empty ##[1:20] park_pop);
  c_irq_raised:   cover property ($rose(irq));

endmodule : umer_reporter

// ===== inc/umer_pkg.sv
// Constants for the unsolicited modem event reporter: register map, field
// positions, reset values, report reason codes and controller states.
// Assumes a 32-bit APB slave with byte addresses on paddr[7:0].
package umer_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_MCTL  = 8'h00;
  localparam logic [7:0] ADDR_PARK  = 8'h04;
  localparam logic [7:0] ADDR_FLAG  = 8'h08;
  localparam logic [7:0] ADDR_IMASK = 8'h0c;
  localparam logic [7:0] ADDR_LASTP = 8'h10;
  localparam logic [7:0] ADDR_LASTA = 8'h14;
  localparam logic [7:0] ADDR_LINES = 8'h18;

  // Modem control parameter word: mask enable and qualifying mask bits
  localparam int MASK_EN_BIT = 16;
  localparam int MASK_LSB    = 17;
  localparam int NUM_LINES   = 7;

  // First parameter longword layout
  localparam int PARAM_REASON_LSB  = 0;
  localparam int PARAM_DETAIL_LSB  = 8;
  localparam int PARAM_PRESENT_BIT = 8;
  localparam int PARAM_STATUS_LSB  = 9;
  localparam logic [7:0] REASON_MODEM = 8'h01;
  localparam logic [7:0] REASON_CABLE = 8'h02;

  // Flag / interrupt status bit positions
  localparam int FLAG_PARK_OVF_BIT           = 0;
  localparam int FLAG_RESPONSE_AVAILABLE_BIT = 14;
  localparam logic [31:0] FLAG_USED          = 32'h0000_4001;

  // Reset values
  localparam logic [31:0] MCTL_RST  = 32'h0000_0000;
  localparam logic [31:0] IMASK_RST = 32'h0000_0000;
  localparam logic [31:0] FLAG_RST  = 32'h0000_0000;

  typedef enum logic [1:0] {ST_IDLE, ST_FILL, ST_QUEUE} umer_state_t;

endpackage : umer_pkg

// ===== sim/umer_reporter_tb.sv
// Self-checking bench for the unsolicited modem event reporter.
// Assumes umer_pkg is compiled first; drives APB, modem lines and the response list directly.
`timescale 1ns/1ps
module umer_reporter_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [6:0]  modem_lines;
  logic [7:0]  cable_code;
  logic        resp_valid;
  logic        resp_ready;
  logic [31:0] resp_addr;
  logic [31:0] resp_param;
  logic        irq;
  int          errors;
  int          tests_run;
  logic [31:0] pq[$];
  logic [31:0] rd;
  logic [6:0]  ln;
  int          j;

  umer_reporter #(.PARK_DEPTH(4)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .modem_lines(modem_lines), .cable_code(cable_code), .resp_valid(resp_valid),
    .resp_ready(resp_ready), .resp_addr(resp_addr), .resp_param(resp_param), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    if (errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= is_wr;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    // No local limit: only the watchdog may end this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = pslverr ? 32'hffff_ffff : prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr

  task automatic park(input logic [31:0] a);
    wr(umer_pkg::ADDR_PARK, a);
    if (pq.size() < 4)
      pq.push_back(a);
  endtask : park

  task automatic set_lines(input logic [6:0] v);
    @(posedge pclk);
    modem_lines <= v;
    ln = v;
  endtask : set_lines

  task automatic quiet;
    logic seen;
    seen = 1'b0;
    repeat (6) begin
      @(posedge pclk);
      if (resp_valid !== 1'b0)
        seen = 1'b1;
    end
    check({31'h0, seen}, 32'h0);
  endtask : quiet

  function automatic logic [31:0] exp_modem(input logic [6:0] v);
    return {16'h0000, v, 1'b1, umer_pkg::REASON_MODEM};
  endfunction : exp_modem

  function automatic logic [31:0] exp_cable(input logic [7:0] c);
    return {16'h0000, c, umer_pkg::REASON_CABLE};
  endfunction : exp_cable

  // Takes the next returned block and checks its address and first parameter
  task automatic take_resp(input logic [31:0] exp_param);
    logic [31:0] ea;
    ea = pq.pop_front();
    while (resp_valid !== 1'b1) begin
      @(posedge pclk);
    end
    check(resp_addr, ea);
    check(resp_param, exp_param);
    resp_ready <= 1'b1;
    @(posedge pclk);
    resp_ready <= 1'b0;
    repeat (2) @(posedge pclk);
    check({31'h0, resp_valid}, 32'h0);
  endtask : take_resp

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    tally_and_finish();
  end

  initial begin
    errors = 0;
    tests_run = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    modem_lines = 7'h00;
    cable_code = 8'h00;
    resp_ready = 1'b0;
    ln = 7'h00;
    void'($urandom(29));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, umer_pkg::ADDR_MCTL, 32'h0, rd);
    check(rd, umer_pkg::MCTL_RST);
    apb(1'b0, umer_pkg::ADDR_FLAG, 32'h0, rd);
    check(rd, umer_pkg::FLAG_RST);
    // Unmapped place answers with an error and reads as all ones here
    apb(1'b0, 8'h1c, 32'h0, rd);
    check(rd, 32'hffff_ffff);
    set_lines(7'($urandom()));
    wr(umer_pkg::ADDR_MCTL, 32'($urandom()));
    apb(1'b0, umer_pkg::ADDR_MCTL, 32'h0, rd);
    check(rd & 32'hff00_ffff, 32'h0);
    wr(umer_pkg::ADDR_IMASK, 32'h0000_4000);
    apb(1'b0, umer_pkg::ADDR_IMASK, 32'h0, rd);
    check(rd, 32'h0000_4000);
    wr(umer_pkg::ADDR_MCTL, 32'h00fe_0000);
    park($urandom());
    set_lines(~ln);
    quiet();
    apb(1'b0, umer_pkg::ADDR_LINES, 32'h0, rd);
    check(rd & 32'h100, 32'h0);
    // One selected line at a time
    for (int i = 0; i < 7; i++) begin
      j = (i + 1) % 7;
      wr(umer_pkg::ADDR_MCTL, (32'h1 << 16) | (32'h1 << (17 + i)));
      park($urandom());
      set_lines(ln ^ 7'(1 << j));
      quiet();
      set_lines(ln ^ 7'(1 << i));
      take_resp(exp_modem(ln));
    end
    // Cable change uses the leftover block
    @(posedge pclk);
    cable_code <= cable_code ^ (8'($urandom()) | 8'h01);
    @(posedge pclk);
    take_resp(exp_cable(cable_code));
    apb(1'b0, umer_pkg::ADDR_LASTP, 32'h0, rd);
    check(rd, exp_cable(cable_code));
    // Event held while no block is parked
    wr(umer_pkg::ADDR_MCTL, 32'h0081_0000);
    set_lines(ln ^ 7'h40);
    quiet();
    apb(1'b0, umer_pkg::ADDR_LINES, 32'h0, rd);
    check(rd & 32'h100, 32'h100);
    set_lines(ln ^ 7'h40);
    park($urandom());
    take_resp(exp_modem(ln));
    // Flag and interrupt after a return
    check({31'h0, irq}, 32'h1);
    apb(1'b0, umer_pkg::ADDR_FLAG, 32'h0, rd);
    check(rd, 32'h0000_4000);
    @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    wr(umer_pkg::ADDR_IMASK, 32'h0);
    park($urandom());
    @(posedge pclk);
    cable_code <= ~cable_code;
    @(posedge pclk);
    take_resp(exp_cable(cable_code));
    check({31'h0, irq}, 32'h0);
    apb(1'b0, umer_pkg::ADDR_FLAG, 32'h0, rd);
    check(rd, 32'h0000_4000);
    // Parked blocks stay put; fifth one is refused
    repeat (5) park($urandom());
    quiet();
    apb(1'b0, umer_pkg::ADDR_PARK, 32'h0, rd);
    check(rd, 32'h4);
    apb(1'b0, umer_pkg::ADDR_FLAG, 32'h0, rd);
    check(rd, 32'h0000_0001);
    // Reset in mid-run empties the parked queue and drops the mask
    pq.delete();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    check({31'h0, resp_valid}, 32'h0);
    apb(1'b0, umer_pkg::ADDR_PARK, 32'h0, rd);
    check(rd, 32'h0);
    apb(1'b0, umer_pkg::ADDR_MCTL, 32'h0, rd);
    check(rd, umer_pkg::MCTL_RST);
    wr(umer_pkg::ADDR_MCTL, 32'h0003_0000);
    park($urandom());
    set_lines(ln ^ 7'h01);
    take_resp(exp_modem(ln));
    tally_and_finish();
  end
endmodule : umer_reporter_tb
